// [hdl/xfer_params.svh]
// offsets, field positions and reset values of the transfer descriptor engine
// assumes an 8-bit byte address on the register bus and 32-bit data
`ifndef XFER_PARAMS_SVH
`define XFER_PARAMS_SVH
// descriptor slots: slot n at byte address n*0x20
`define DESC_NUM     4
`define DESC_MODE_A  5'h00
`define DESC_MODE_B  5'h04
`define DESC_SRC     5'h08
`define DESC_DST     5'h0c
`define DESC_CNT     5'h10
`define DESC_BLK     5'h14
// global registers
`define REG_CTRL     8'h80
`define REG_STATUS   8'h84
`define REG_MASK     8'h88
`define REG_STATE    8'h8c
// transfer_mode_reg_a fields
`define MA_MODE      7:6
`define MA_SIZE      5:4
`define MA_SSTEP     3:2
// transfer_mode_reg_b fields
`define MB_CHAIN     7
`define MB_CCOND     6
`define MB_IRQALL    5
`define MB_AREA      4
`define MB_DSTEP     3:2
// control and status fields
`define CTRL_SHORT   0
`define CTRL_START   1
`define CTRL_IDX     3:2
`define STAT_DONE    0
`define STAT_ERR     1
// reset values and bus answers
`define DESC_RST8    8'h00
`define DESC_RST32   32'h0000_0000
`define CTRL_RST     1'h0
`define MASK_RST     2'h0
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// [hdl/xfer_pkg.sv]
// types shared by the transfer descriptor engine
// assumes nothing of its surroundings
package xfer_pkg;
	typedef enum logic [1:0] {SIZE_BYTE = 2'h0, SIZE_WORD = 2'h1, SIZE_LONG = 2'h2, SIZE_BAD = 2'h3} size_t;
	typedef enum logic [1:0] {MODE_NORMAL = 2'h0, MODE_REPEAT = 2'h1, MODE_BLOCK = 2'h2, MODE_BAD = 2'h3} mode_t;
	typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_ISSUE, ST_WAIT, ST_UPDATE} state_t;
endpackage : xfer_pkg

// [hdl/xfer_ifs.sv]
// carriers between the engine and its pointer and interrupt units
// assumes one clock, driven by the engine's module
`timescale 1ns/100ps
interface ptr_if;
	logic [31:0]        ptr;
	logic [1:0]         step;
	xfer_pkg::size_t    size;
	logic               short_mode;
	logic               restore;
	logic [7:0]         reload;
	logic [31:0]        eff;
	logic [31:0]        nxt;
	modport user (output ptr, step, size, short_mode, restore, reload, input eff, nxt);
	modport unit (input ptr, step, size, short_mode, restore, reload, output eff, nxt);
endinterface : ptr_if

interface irq_if;
	logic [1:0] ev;
	logic       rd_clr;
	logic       mask_we;
	logic [1:0] mask_wdata;
	logic [1:0] status;
	logic [1:0] mask;
	modport user (output ev, rd_clr, mask_we, mask_wdata, input status, mask);
	modport unit (input ev, rd_clr, mask_we, mask_wdata, output status, mask);
endinterface : irq_if

// [hdl/ptr_step.sv]
// address arithmetic for one transfer pointer: effective address and next value
// assumes size never holds the prohibited code; the engine refuses it earlier
`timescale 1ns/100ps
module ptr_step (
	ptr_if.unit p
);
	import xfer_pkg::*;
	logic [31:0] amount;
	logic [31:0] base;
	logic [31:0] back;
	logic [31:0] stepped;

	// unit size and repeat/block rewind distance; reload 0 stands for 256 units
	assign amount  = 32'h1 << p.size;
	assign base    = (p.reload == 8'h00) ? 32'h100 : {24'h0, p.reload};
	assign back    = base << p.size;
	assign stepped = (p.step == 2'h2) ? p.ptr + amount : (p.step == 2'h3) ? p.ptr - amount : p.ptr;
	// rewind walks back over the whole area, so no start copy is needed
	assign p.nxt   = (!p.restore || !p.step[1]) ? stepped : p.step[0] ? stepped + back : stepped - back;
	// short mode drops b31..b24 and refills them from b23
	assign p.eff   = p.short_mode ? {{8{p.ptr[23]}}, p.ptr[23:0]} : p.ptr;
endmodule : ptr_step

// [hdl/irq_unit.sv]
// sticky event status, mask and the level interrupt output
// assumes events and read-clear arrive as one-cycle pulses from the engine
`timescale 1ns/100ps
`include "xfer_params.svh"
module irq_unit (
	input  wire logic clk_i,
	input  wire logic rst_i,
	irq_if.unit       ic,
	output logic      irq_o
);
	import xfer_pkg::*;
	logic [1:0] status_r;
	logic [1:0] mask_r;
	logic       irq_r;
	logic [1:0] status_nxt;

	// a set in the clearing cycle survives the clear
	assign status_nxt = (ic.rd_clr ? 2'h0 : status_r) | ic.ev;
	assign ic.status  = status_r;
	assign ic.mask    = mask_r;
	assign irq_o      = irq_r;

	// status, mask and the registered interrupt level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_r <= 2'h0;
			mask_r   <= `MASK_RST;
			irq_r    <= 1'h0;
		end else begin
			status_r <= status_nxt;
			if (ic.mask_we) mask_r <= ic.mask_wdata;
			irq_r    <= |(status_r & mask_r);
		end
	end

	property p_set_wins;
		@(posedge clk_i) disable iff (rst_i) ic.ev[`STAT_DONE] |=> status_r[`STAT_DONE];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost under read clear");
endmodule : irq_unit

// [hdl/transfer_info_decoder.sv]
// descriptor-driven transfer engine with an AXI4-Lite register file
// assumes a memory port that acknowledges each unit with a one-cycle pulse
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "xfer_params.svh"

// Operation
// - area side bit 0 makes destination the repeat/block area, 1 the source
// - size field 00 byte, 01 word, 10 longword; 11 is refused
// - chain enable 1 runs a chained transfer afterwards; 0 never chains
// - irq_every_transfer 0 interrupts at count end only; 1 after every transfer
// - chain condition 0 chains after every transfer
// - chain condition 1 chains only when counter goes 1 to 0 or reloads
// - full-address mode uses all 32 pointer bits
// - short-address mode uses the low 24 bits, ignoring b31..b24
// - short-address mode fills the upper bits from b23
// - step 0X fixed without write-back, 10 increments, 11 decrements by size
// - mode field 00 normal, 01 repeat, 10 block; 11 is refused
// - block mode counts blocks down and ends when the block counter hits zero
module transfer_info_decoder (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic [7:0]    awaddr_i,
	input  wire logic          awvalid_i,
	output logic               awready_o,
	input  wire logic [31:0]   wdata_i,
	input  wire logic [3:0]    wstrb_i,
	input  wire logic          wvalid_i,
	output logic               wready_o,
	output logic [1:0]         bresp_o,
	output logic               bvalid_o,
	input  wire logic          bready_i,
	input  wire logic [7:0]    araddr_i,
	input  wire logic          arvalid_i,
	output logic               arready_o,
	output logic [31:0]        rdata_o,
	output logic [1:0]         rresp_o,
	output logic               rvalid_o,
	input  wire logic          rready_i,
	input  wire logic          act_i,
	input  wire logic [1:0]    act_idx_i,
	output logic               mem_req_o,
	output logic [31:0]        mem_src_o,
	output logic [31:0]        mem_dst_o,
	output xfer_pkg::size_t    mem_size_o,
	input  wire logic          mem_ack_i,
	output logic               busy_o,
	output logic               irq_o
);
	import xfer_pkg::*;

	// ********************************************************************
	// declarations and helpers
	// ********************************************************************
	logic [7:0]  mode_a_r [`DESC_NUM];
	logic [7:0]  mode_b_r [`DESC_NUM];
	logic [31:0] src_r    [`DESC_NUM];
	logic [31:0] dst_r    [`DESC_NUM];
	logic [15:0] cnt_r    [`DESC_NUM];
	logic [15:0] blk_r    [`DESC_NUM];
	logic        aw_rdy_r, w_rdy_r, aw_hold_r, w_hold_r, bvalid_r, ar_rdy_r, rvalid_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r, rdata_r;
	logic [3:0]  w_strb_r;
	logic [1:0]  bresp_r, rresp_r;
	logic        short_r;
	state_t      state_r;
	logic [1:0]  idx_r;
	logic [7:0]  wa_r, wb_r;
	logic [31:0] wsrc_r, wdst_r, msrc_r, mdst_r;
	logic [15:0] wcnt_r, wblk_r;
	logic        hit_r, end_r, req_r, busy_r;
	size_t       msize_r;
	mode_t       cur_mode;
	size_t       cur_size;
	logic        bad_cfg, low_last, reload_now, chain_go;
	logic [7:0]  cnt_low;
	ptr_if       src_p ();
	ptr_if       dst_p ();
	irq_if       ic ();

	// byte-lane merge for wide registers
	function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction : merge32

	// one address map shared by the read and write paths
	function automatic logic reg_ok(input logic [7:0] a);
		if (a[7]) return (a[6:4] == 3'h0) && (a[1:0] == 2'h0);
		else return (a[4:0] <= `DESC_BLK) && (a[1:0] == 2'h0);
	endfunction : reg_ok

	// ********************************************************************
	// AXI4-Lite slave
	// ********************************************************************
	logic        aw_take, w_take, wr_fire, b_take, ar_take, r_take, wr_ok, desc_we;
	logic        start_pulse, ar_ok;
	logic [1:0]  widx, ridx;
	logic [4:0]  wreg, rreg;
	logic [31:0] rd_desc, rd_glob, rd_word, cnt_m, blk_m;

	// handshakes and write decode; one write and one read outstanding at most
	assign aw_take     = awvalid_i && aw_rdy_r;
	assign w_take      = wvalid_i && w_rdy_r;
	assign wr_fire     = aw_hold_r && w_hold_r && !bvalid_r;
	assign b_take      = bvalid_r && bready_i;
	assign ar_take     = arvalid_i && ar_rdy_r;
	assign r_take      = rvalid_r && rready_i;
	assign wr_ok       = reg_ok(aw_addr_r);
	assign widx        = aw_addr_r[6:5];
	assign wreg        = aw_addr_r[4:0];
	assign desc_we     = wr_fire && wr_ok && !aw_addr_r[7];
	assign start_pulse = wr_fire && (aw_addr_r == `REG_CTRL) && w_strb_r[0] && w_data_r[`CTRL_START];
	assign ic.mask_we    = wr_fire && (aw_addr_r == `REG_MASK) && w_strb_r[0];
	assign ic.mask_wdata = w_data_r[1:0];
	// counter words merged by lane before the 16-bit store
	assign cnt_m = merge32({16'h0, cnt_r[widx]}, w_data_r, w_strb_r);
	assign blk_m = merge32({16'h0, blk_r[widx]}, w_data_r, w_strb_r);

	// read decode; status clears as it is read
	assign ar_ok    = reg_ok(araddr_i);
	assign ridx     = araddr_i[6:5];
	assign rreg     = araddr_i[4:0];
	assign rd_desc  = (rreg == `DESC_MODE_A) ? {24'h0, mode_a_r[ridx]} :
	                  (rreg == `DESC_MODE_B) ? {24'h0, mode_b_r[ridx]} :
	                  (rreg == `DESC_SRC)    ? src_r[ridx] :
	                  (rreg == `DESC_DST)    ? dst_r[ridx] :
	                  (rreg == `DESC_CNT)    ? {16'h0, cnt_r[ridx]} : {16'h0, blk_r[ridx]};
	assign rd_glob  = (araddr_i == `REG_CTRL)   ? {31'h0, short_r} :
	                  (araddr_i == `REG_STATUS) ? {30'h0, ic.status} :
	                  (araddr_i == `REG_MASK)   ? {30'h0, ic.mask} : {29'h0, idx_r, busy_o};
	assign rd_word  = !ar_ok ? 32'h0 : araddr_i[7] ? rd_glob : rd_desc;
	assign ic.rd_clr = ar_take && (araddr_i == `REG_STATUS);

	// write channel capture and response
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_rdy_r  <= 1'h1;
			w_rdy_r   <= 1'h1;
			aw_hold_r <= 1'h0;
			w_hold_r  <= 1'h0;
			bvalid_r  <= 1'h0;
			bresp_r   <= `RESP_OKAY;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0;
			w_strb_r  <= 4'h0;
			short_r   <= `CTRL_RST;
		end else begin
			if (aw_take) begin
				aw_addr_r <= awaddr_i;
				aw_hold_r <= 1'h1;
				aw_rdy_r  <= 1'h0;
			end
			if (w_take) begin
				w_data_r <= wdata_i;
				w_strb_r <= wstrb_i;
				w_hold_r <= 1'h1;
				w_rdy_r  <= 1'h0;
			end
			if (wr_fire) begin
				aw_hold_r <= 1'h0;
				w_hold_r  <= 1'h0;
				bvalid_r  <= 1'h1;
				bresp_r   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
				if (aw_addr_r == `REG_CTRL && w_strb_r[0]) short_r <= w_data_r[`CTRL_SHORT];
			end
			if (b_take) begin
				bvalid_r <= 1'h0;
				aw_rdy_r <= 1'h1;
				w_rdy_r  <= 1'h1;
			end
		end
	end

	// read channel: data captured at the address handshake
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ar_rdy_r <= 1'h1;
			rvalid_r <= 1'h0;
			rdata_r  <= 32'h0;
			rresp_r  <= `RESP_OKAY;
		end else if (ar_take) begin
			ar_rdy_r <= 1'h0;
			rvalid_r <= 1'h1;
			rdata_r  <= rd_word;
			rresp_r  <= ar_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (r_take) begin
			ar_rdy_r <= 1'h1;
			rvalid_r <= 1'h0;
		end
	end

	// ********************************************************************
	// descriptor store
	// ********************************************************************
	// the engine's write-back comes last so it beats a same-cycle bus write
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `DESC_NUM; i++) begin
				mode_a_r[i] <= `DESC_RST8;
				mode_b_r[i] <= `DESC_RST8;
				src_r[i]    <= `DESC_RST32;
				dst_r[i]    <= `DESC_RST32;
				cnt_r[i]    <= 16'h0;
				blk_r[i]    <= 16'h0;
			end
		end else begin
			if (desc_we) begin
				if (wreg == `DESC_MODE_A && w_strb_r[0]) mode_a_r[widx] <= w_data_r[7:0];
				else if (wreg == `DESC_MODE_B && w_strb_r[0]) mode_b_r[widx] <= w_data_r[7:0];
				else if (wreg == `DESC_SRC) src_r[widx] <= merge32(src_r[widx], w_data_r, w_strb_r);
				else if (wreg == `DESC_DST) dst_r[widx] <= merge32(dst_r[widx], w_data_r, w_strb_r);
				else if (wreg == `DESC_CNT) cnt_r[widx] <= cnt_m[15:0];
				else if (wreg == `DESC_BLK) blk_r[widx] <= blk_m[15:0];
			end
			if (state_r == ST_UPDATE) begin
				if (wa_r[3]) src_r[idx_r] <= wsrc_r;
				if (wb_r[3]) dst_r[idx_r] <= wdst_r;
				cnt_r[idx_r] <= wcnt_r;
				if (cur_mode == MODE_BLOCK) blk_r[idx_r] <= wblk_r;
			end
		end
	end

	// ********************************************************************
	// transfer engine
	// ********************************************************************
	assign cur_mode   = mode_t'(wa_r[`MA_MODE]);
	assign cur_size   = size_t'(wa_r[`MA_SIZE]);
	assign bad_cfg    = (mode_a_r[idx_r][`MA_MODE] == MODE_BAD) || (mode_a_r[idx_r][`MA_SIZE] == SIZE_BAD);
	assign cnt_low    = wcnt_r[7:0];
	assign low_last   = (cnt_low == 8'h01);
	assign reload_now = (cur_mode != MODE_NORMAL) && low_last;
	// unconditional chain, or only on the counter's last step
	assign chain_go   = wb_r[`MB_CHAIN] && (!wb_r[`MB_CCOND] || hit_r);

	// pointer units; only the area side rewinds at a reload
	assign src_p.ptr        = wsrc_r;
	assign src_p.step       = wa_r[`MA_SSTEP];
	assign src_p.size       = cur_size;
	assign src_p.short_mode = short_r;
	assign src_p.restore    = reload_now && wb_r[`MB_AREA];
	assign src_p.reload     = wcnt_r[15:8];
	assign dst_p.ptr        = wdst_r;
	assign dst_p.step       = wb_r[`MB_DSTEP];
	assign dst_p.size       = cur_size;
	assign dst_p.short_mode = short_r;
	assign dst_p.restore    = reload_now && !wb_r[`MB_AREA];
	assign dst_p.reload     = wcnt_r[15:8];
	ptr_step u_src_step (.p(src_p));
	ptr_step u_dst_step (.p(dst_p));

	// events: done by interrupt selection, error on a prohibited setting
	assign ic.ev[`STAT_DONE] = (state_r == ST_UPDATE) && (wb_r[`MB_IRQALL] || end_r);
	assign ic.ev[`STAT_ERR]  = (state_r == ST_LOAD) && bad_cfg;
	irq_unit u_irq (.clk_i(clk_i), .rst_i(rst_i), .ic(ic), .irq_o(irq_o));

	// engine state; activations are ignored while busy
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			idx_r   <= 2'h0;
			wa_r    <= 8'h00;
			wb_r    <= 8'h00;
			wsrc_r  <= 32'h0;
			wdst_r  <= 32'h0;
			wcnt_r  <= 16'h0;
			wblk_r  <= 16'h0;
			hit_r   <= 1'h0;
			end_r   <= 1'h0;
			req_r   <= 1'h0;
			busy_r  <= 1'h0;
			msrc_r  <= 32'h0;
			mdst_r  <= 32'h0;
			msize_r <= SIZE_BYTE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					busy_r <= start_pulse || act_i;
					if (start_pulse) begin
						idx_r   <= w_data_r[`CTRL_IDX];
						state_r <= ST_LOAD;
					end else if (act_i) begin
						idx_r   <= act_idx_i;
						state_r <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					wa_r    <= mode_a_r[idx_r];
					wb_r    <= mode_b_r[idx_r];
					wsrc_r  <= src_r[idx_r];
					wdst_r  <= dst_r[idx_r];
					wcnt_r  <= cnt_r[idx_r];
					wblk_r  <= blk_r[idx_r];
					state_r <= bad_cfg ? ST_IDLE : ST_ISSUE;
					busy_r  <= !bad_cfg;
				end
				ST_ISSUE: begin
					req_r   <= 1'h1;
					msrc_r  <= src_p.eff;
					mdst_r  <= dst_p.eff;
					msize_r <= cur_size;
					state_r <= ST_WAIT;
				end
				ST_WAIT: begin
					if (mem_ack_i) begin
						req_r  <= 1'h0;
						wsrc_r <= src_p.nxt;
						wdst_r <= dst_p.nxt;
						if (cur_mode == MODE_NORMAL) begin
							wcnt_r  <= wcnt_r - 16'h1;
							hit_r   <= (wcnt_r == 16'h1);
							end_r   <= (wcnt_r == 16'h1);
							state_r <= ST_UPDATE;
						end else begin
							wcnt_r[7:0] <= low_last ? wcnt_r[15:8] : cnt_low - 8'h1;
							hit_r       <= low_last;
							end_r       <= (cur_mode == MODE_BLOCK) && low_last && (wblk_r == 16'h1);
							if (cur_mode == MODE_BLOCK && low_last) wblk_r <= wblk_r - 16'h1;
							state_r     <= (cur_mode == MODE_BLOCK && !low_last) ? ST_ISSUE : ST_UPDATE;
						end
					end
				end
				ST_UPDATE: begin
					busy_r <= chain_go;
					if (chain_go) begin
						idx_r   <= idx_r + 2'h1;
						state_r <= ST_LOAD;
					end else begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					busy_r  <= 1'h0;
				end
			endcase
		end
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	assign awready_o  = aw_rdy_r;
	assign wready_o   = w_rdy_r;
	assign bvalid_o   = bvalid_r;
	assign bresp_o    = bresp_r;
	assign arready_o  = ar_rdy_r;
	assign rvalid_o   = rvalid_r;
	assign rdata_o    = rdata_r;
	assign rresp_o    = rresp_r;
	assign mem_req_o  = req_r;
	assign mem_src_o  = msrc_r;
	assign mem_dst_o  = mdst_r;
	assign mem_size_o = msize_r;
	assign busy_o     = busy_r;

	// ********************************************************************
	// assertions
	// ********************************************************************
	sequence s_last_block;
		state_r == ST_WAIT && mem_ack_i && cur_mode == MODE_BLOCK && low_last && wblk_r == 16'h1;
	endsequence
	sequence s_update_end;
		state_r == ST_UPDATE && end_r;
	endsequence
	property p_area_side;
		@(posedge clk_i) disable iff (rst_i) (state_r == ST_WAIT && mem_ack_i && reload_now && wb_r[`MB_AREA]
			&& wa_r[`MA_SSTEP] == 2'h2 && wcnt_r[15:8] == 8'h01) |=> wsrc_r == $past(wsrc_r);
	endproperty
	a_area_side: assert property (p_area_side) else $error("source area not rewound");
	property p_size_map;
		@(posedge clk_i) disable iff (rst_i) state_r == ST_ISSUE |=> mem_size_o == size_t'($past(wa_r[`MA_SIZE]));
	endproperty
	a_size_map: assert property (p_size_map) else $error("size field not passed to memory port");
	property p_chain_off;
		@(posedge clk_i) disable iff (rst_i) (state_r == ST_UPDATE && !wb_r[`MB_CHAIN]) |=> state_r == ST_IDLE;
	endproperty
	a_chain_off: assert property (p_chain_off) else $error("chain taken while disabled");
	property p_irq_all;
		@(posedge clk_i) disable iff (rst_i) (state_r == ST_UPDATE && wb_r[`MB_IRQALL]) |=> ic.status[`STAT_DONE];
	endproperty
	a_irq_all: assert property (p_irq_all) else $error("per-transfer interrupt missing");
	property p_chain_always;
		@(posedge clk_i) disable iff (rst_i) (state_r == ST_UPDATE && wb_r[`MB_CHAIN] && !wb_r[`MB_CCOND])
			|=> state_r == ST_LOAD && idx_r == $past(idx_r) + 2'h1 ##1 state_r != ST_IDLE;
	endproperty
	a_chain_always: assert property (p_chain_always) else $error("unconditional chain not taken");
	property p_chain_cond;
		@(posedge clk_i) disable iff (rst_i) (state_r == ST_UPDATE && wb_r[`MB_CHAIN] && wb_r[`MB_CCOND] && !hit_r)
			|=> state_r == ST_IDLE;
	endproperty
	a_chain_cond: assert property (p_chain_cond) else $error("conditional chain taken early");
	property p_full_addr;
		@(posedge clk_i) disable iff (rst_i) (state_r == ST_ISSUE && !short_r) |=> mem_src_o == $past(wsrc_r);
	endproperty
	a_full_addr: assert property (p_full_addr) else $error("full address altered");
	property p_short_addr;
		@(posedge clk_i) disable iff (rst_i) (state_r == ST_ISSUE && short_r)
			|=> mem_dst_o[31:24] == {8{mem_dst_o[23]}} && mem_dst_o[23:0] == $past(wdst_r[23:0]);
	endproperty
	a_short_addr: assert property (p_short_addr) else $error("short address not extended from b23");
	property p_fixed;
		@(posedge clk_i) disable iff (rst_i) (state_r == ST_WAIT && mem_ack_i && !wa_r[3]) |=> wsrc_r == $past(wsrc_r);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed source pointer moved");
	property p_bad_mode;
		@(posedge clk_i) disable iff (rst_i) (state_r == ST_LOAD && bad_cfg) |=> state_r == ST_IDLE ##1 !mem_req_o;
	endproperty
	a_bad_mode: assert property (p_bad_mode) else $error("prohibited setting executed");
	property p_block_end;
		@(posedge clk_i) disable iff (rst_i) s_last_block |=> s_update_end ##1 state_r != ST_ISSUE;
	endproperty
	a_block_end: assert property (p_block_end) else $error("block transfer did not end");
endmodule : transfer_info_decoder

// [tb/mem_model.sv]
// memory-side partner: acknowledges each unit request after a chosen lag
// assumes one clock shared with the engine and a level request
`timescale 1ns/100ps
module mem_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       req_i,
	input  wire logic [3:0] lag_i,
	output logic            ack_o
);
	logic [3:0] wait_r;
	// one-cycle pulse; never twice in a row, since a high ack_o blocks the next cycle's ack
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_r <= 4'h0;
			ack_o  <= 1'b0;
		end else begin
			ack_o  <= req_i && !ack_o && wait_r >= lag_i;
			wait_r <= (req_i && !ack_o) ? wait_r + 4'h1 : 4'h0;
		end
	end
endmodule : mem_model

// [tb/tb.sv]
// self-checking bench of the transfer engine, random and corner cases
// assumes mem_model on the memory port
`timescale 1ns/100ps
module tb;
	import xfer_pkg::*;
	logic        clk_i, rst_i, awvalid, awready, wvalid, wready, bready, bvalid, arvalid, arready;
	logic        rvalid, rready, act, ack, req, busy, irq, sh;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, src, dst, csrc, cdst, msrc, mdst;
	logic [1:0]  bresp, rresp, sz, ss, ds;
	logic [3:0]  lag;
	size_t       msz, csz;
	integer      seed, errors, checks, nreq, n0, i;
	mem_model mdl (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .lag_i(lag), .ack_o(ack));
	transfer_info_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
		.awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid), .wready_o(wready),
		.bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
		.arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
		.act_i(act), .act_idx_i(2'h0), .mem_req_o(req), .mem_src_o(msrc), .mem_dst_o(mdst),
		.mem_size_o(msz), .mem_ack_i(ack), .busy_o(busy), .irq_o(irq));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// capture what the engine offers at each acknowledged unit
	always @(posedge clk_i) if (req && ack) begin
		nreq <= nreq + 1;
		csrc <= msrc;
		cdst <= mdst;
		csz  <= msz;
	end
	function automatic logic [31:0] ext(input logic [31:0] a, input logic s);
		return s ? {{8{a[23]}}, a[23:0]} : a;
	endfunction : ext
	function automatic logic [31:0] nxt(input logic [31:0] a, input logic [1:0] st, z);
		return st[1] ? (st[0] ? a - (32'h1 << z) : a + (32'h1 << z)) : a;
	endfunction : nxt
	task automatic chk(input logic [31:0] g, e, input string m);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	// address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (awvalid || wvalid) begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid) @(posedge clk_i);
		rd = {30'h0, bresp};
		bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a);
		@(posedge clk_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk_i); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk_i); while (!rvalid);
		rready <= 1'b0;
		rd = rdata;
	endtask : axr
	task automatic chkr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		axr(a);
		chk(rd, e, "read data");
		chk({30'h0, rresp}, {30'h0, r}, "read resp");
	endtask : chkr
	task automatic desc(input logic [7:0] b, ma, mb, input logic [31:0] s, d, c);
		axw(b, {24'h0, ma});
		axw(b + 8'h04, {24'h0, mb});
		axw(b + 8'h08, s);
		axw(b + 8'h0c, d);
		axw(b + 8'h10, c);
	endtask : desc
	// start by pin or by control write; no fixed latency assumed for busy
	task automatic go(input logic s, pin);
		axw(8'h80, {30'h0, !pin, s});
		if (pin) begin
			act <= 1'b1;
			@(posedge clk_i);
			act <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		while (busy) @(posedge clk_i);
		repeat (2) @(posedge clk_i);
	endtask : go
	task automatic test_done;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		test_done();
	end
	initial begin
		seed = 32'h0c19eb27;
		{errors, checks, nreq} = '0;
		{awvalid, wvalid, bready, arvalid, rready, act, awaddr, araddr, wdata, lag} = '0;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chkr(8'h00, 32'h0, 2'h0);
		chkr(8'h90, 32'h0, 2'h2);
		axw(8'h90, 32'h5);
		chk(rd, 32'h2, "write resp");
		axw(8'h88, 32'h1);
		chk(rd, 32'h0, "write resp");
		// single normal units: every size, random step codes, both address modes
		for (i = 0; i < 9; i++) begin
			sz = 2'(i % 3);
			{ss, ds, lag} = 8'($random(seed));
			src = $random(seed);
			dst = $random(seed);
			sh = i[0];
			n0 = nreq;
			desc(8'h00, {2'h0, sz, ss, 2'h0}, {4'h0, ds, 2'h0}, src, dst, 32'h1);
			go(sh, i[1]);
			chk(nreq - n0, 1, "units");
			chk(csrc, ext(src, sh), "source");
			chk(cdst, ext(dst, sh), "destination");
			chk({30'h0, csz}, {30'h0, sz}, "size");
			chk({31'h0, irq}, 32'h1, "irq");
			axr(8'h08);
			chk(rd & 32'hffffff, nxt(src, ss, sz) & 32'hffffff, "src back");
			axr(8'h0c);
			chk(rd & 32'hffffff, nxt(dst, ds, sz) & 32'hffffff, "dst back");
			chkr(8'h84, 32'h1, 2'h0);
			repeat (2) @(posedge clk_i);
			chk({31'h0, irq}, 32'h0, "irq clear");
		end
		// prohibited size then mode: error flagged, nothing moved
		for (i = 0; i < 2; i++) begin
			n0 = nreq;
			desc(8'h00, i ? 8'hc0 : 8'h30, 8'h00, src, dst, 32'h1);
			go(1'b0, 1'b0);
			chk(nreq - n0, 0, "refused");
			chkr(8'h84, 32'h2, 2'h0);
		end
		// chain into slot 1: unconditional, then only at count end
		desc(8'h20, 8'h00, 8'h00, src, dst, 32'h1);
		desc(8'h00, 8'h00, 8'h80, src, dst, 32'h1);
		n0 = nreq;
		go(1'b0, 1'b1);
		chk(nreq - n0, 2, "chained");
		chkr(8'h84, 32'h1, 2'h0);
		desc(8'h00, 8'h00, 8'hc0, src, dst, 32'h2);
		axw(8'h30, 32'h1);
		for (i = 2; i > 0; i--) begin
			n0 = nreq;
			go(1'b0, 1'b1);
			chk(nreq - n0, 3 - i, "conditional chain");
			chkr(8'h84, 2 - i, 2'h0);
		end
		// repeat with the source as area, reload 1: source rewinds, destination steps
		desc(8'h00, 8'h68, 8'h38, src, dst, 32'h0101);
		n0 = nreq;
		go(1'b0, 1'b1);
		chk(nreq - n0, 1, "repeat units");
		chkr(8'h08, src, 2'h0);
		chkr(8'h0c, dst + 32'h4, 2'h0);
		chkr(8'h10, 32'h0101, 2'h0);
		chkr(8'h84, 32'h1, 2'h0);
		// one block of two bytes, destination as area: block counter ends the transfer
		desc(8'h00, 8'h88, 8'h08, src, dst, 32'h0202);
		axw(8'h14, 32'h1);
		n0 = nreq;
		go(1'b0, 1'b0);
		chk(nreq - n0, 2, "block units");
		chkr(8'h08, src + 32'h2, 2'h0);
		chkr(8'h0c, dst, 2'h0);
		chkr(8'h14, 32'h0, 2'h0);
		chkr(8'h84, 32'h1, 2'h0);
		test_done();
	end
endmodule : tb
